/* File: core/xmo_pkg.sv */
package xmo_pkg;

    // APB address width and register byte offsets.
    localparam int XMO_PAW = 8;
    localparam logic [7:0] XMO_OFS_CMD = 8'h00;
    localparam logic [7:0] XMO_OFS_WORK = 8'h04;
    localparam logic [7:0] XMO_OFS_FLAGS = 8'h08;
    localparam logic [7:0] XMO_OFS_STAT = 8'h0c;
    localparam logic [7:0] XMO_OFS_PTR = 8'h10;
    localparam logic [7:0] XMO_OFS_DATA = 8'h14;

    // Command word fields.
    localparam int XMO_CMD_OP_LSB = 0;
    localparam int XMO_CMD_BIT_LSB = 8;
    localparam int XMO_CMD_ADDR_LSB = 16;

    // Status flag positions inside the flag register.
    localparam int XMO_F_C = 0;
    localparam int XMO_F_AC = 1;
    localparam int XMO_F_Z = 2;
    localparam int XMO_F_OV = 3;
    localparam int XMO_F_SC = 4;
    localparam int XMO_F_CZ = 5;

    // Status register fields.
    localparam int XMO_ST_BUSY = 0;
    localparam int XMO_ST_SKIP = 1;
    localparam int XMO_ST_CYC_LSB = 8;

    // Reset values and cycle counts of one operation.
    localparam logic [7:0] XMO_WORK_RST = 8'h00;
    localparam logic [5:0] XMO_FLAGS_RST = 6'h00;
    localparam logic [3:0] XMO_BASE_CYCLES = 4'h2;
    localparam logic [3:0] XMO_SKIP_CYCLES = 4'h3;

    // Operation codes of the extended memory group.
    typedef enum logic [4:0] {
        OP_FAR_STORE_FROM_WORK = 5'h00,
        OP_FAR_UNION_TO_WORK = 5'h01,
        OP_FAR_UNION_TO_MEMORY = 5'h02,
        OP_FAR_ROTATE_LEFT = 5'h03,
        OP_FAR_ROTATE_LEFT_TO_WORK = 5'h04,
        OP_FAR_ROTATE_LEFT_VIA_CARRY = 5'h05,
        OP_FAR_ROTATE_LEFT_VIA_CARRY_TO_WORK = 5'h06,
        OP_FAR_ROTATE_RIGHT = 5'h07,
        OP_FAR_ROTATE_RIGHT_TO_WORK = 5'h08,
        OP_FAR_ROTATE_RIGHT_VIA_CARRY = 5'h09,
        OP_FAR_ROTATE_RIGHT_VIA_CARRY_TO_WORK = 5'h0a,
        OP_FAR_MINUS_WITH_BORROW_TO_WORK = 5'h0b,
        OP_FAR_MINUS_WITH_BORROW_TO_MEMORY = 5'h0c,
        OP_FAR_DECREMENT_SKIP_IF_NIL = 5'h0d,
        OP_FAR_DECREMENT_SKIP_TO_WORK = 5'h0e,
        OP_FAR_FILL_ONES = 5'h0f,
        OP_FAR_FILL_ONES_BIT = 5'h10,
        OP_FAR_INCREMENT_SKIP_IF_NIL = 5'h11,
        OP_FAR_INCREMENT_SKIP_TO_WORK = 5'h12,
        OP_FAR_SKIP_IF_NONNIL = 5'h13,
        OP_FAR_SKIP_IF_NONNIL_BIT = 5'h14,
        OP_FAR_MINUS_TO_WORK = 5'h15,
        OP_FAR_MINUS_TO_MEMORY = 5'h16
    } xmo_op_e;

    localparam logic [4:0] XMO_OP_LAST = 5'h16;

    // One-hot execution states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_EXEC = 4'b0100,
        ST_DUMMY = 4'b1000
    } xmo_state_e;

endpackage

/* File: core/xmo_alu_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Operands in, result and write steering out of the combinational datapath.
interface xmo_alu_if;
    import xmo_pkg::*;
    xmo_op_e op;
    logic [2:0] bsel;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [5:0] flags_in;
    logic [7:0] result;
    logic [5:0] flags_out;
    logic to_work;
    logic to_mem;
    logic skip;
    modport core (output op, bsel, acc, opnd, flags_in,
                  input result, flags_out, to_work, to_mem, skip);
    modport alu (input op, bsel, acc, opnd, flags_in,
                 output result, flags_out, to_work, to_mem, skip);
endinterface
`default_nettype wire

/* File: core/xmo_alu.sv */
`timescale 1ns/1ns
`default_nettype none
module xmo_alu (
    xmo_alu_if.alu a
);
    import xmo_pkg::*;

    logic sbc;
    logic cin;
    logic [8:0] dif;
    logic [4:0] nib;
    logic [7:0] mask;
    logic [7:0] rl;
    logic [7:0] rr;
    logic [7:0] dec;
    logic [7:0] inc;

    // Subtraction as add of the inverse; the ninth bit is the no-borrow carry.
    assign sbc = (a.op == OP_FAR_MINUS_WITH_BORROW_TO_WORK) ||
                 (a.op == OP_FAR_MINUS_WITH_BORROW_TO_MEMORY);
    assign cin = sbc ? a.flags_in[XMO_F_C] : 1'b1;
    assign dif = {1'b0, a.acc} + {1'b0, ~a.opnd} + {8'h00, cin};
    assign nib = {1'b0, a.acc[3:0]} + {1'b0, ~a.opnd[3:0]} + {4'h0, cin};
    assign mask = 8'h01 << a.bsel;
    assign rl = {a.opnd[6:0], a.opnd[7]};
    assign rr = {a.opnd[0], a.opnd[7:1]};
    assign dec = a.opnd - 8'h01;
    assign inc = a.opnd + 8'h01;

    // Flags start as the old ones, so only named flags ever move.
    always_comb begin
        a.result = a.opnd;
        a.flags_out = a.flags_in;
        a.to_work = 1'b0;
        a.to_mem = 1'b0;
        a.skip = 1'b0;
        case (a.op)
            OP_FAR_STORE_FROM_WORK: begin
                a.result = a.acc;
                a.to_mem = 1'b1;
            end
            OP_FAR_UNION_TO_WORK, OP_FAR_UNION_TO_MEMORY: begin
                a.result = a.acc | a.opnd;
                a.to_work = (a.op == OP_FAR_UNION_TO_WORK);
                a.to_mem = (a.op == OP_FAR_UNION_TO_MEMORY);
                a.flags_out[XMO_F_Z] = ((a.acc | a.opnd) == 8'h00);
            end
            OP_FAR_ROTATE_LEFT, OP_FAR_ROTATE_LEFT_TO_WORK: begin
                a.result = rl;
                a.to_work = (a.op == OP_FAR_ROTATE_LEFT_TO_WORK);
                a.to_mem = (a.op == OP_FAR_ROTATE_LEFT);
            end
            OP_FAR_ROTATE_LEFT_VIA_CARRY, OP_FAR_ROTATE_LEFT_VIA_CARRY_TO_WORK: begin
                a.result = {a.opnd[6:0], a.flags_in[XMO_F_C]};
                a.flags_out[XMO_F_C] = a.opnd[7];
                a.to_work = (a.op == OP_FAR_ROTATE_LEFT_VIA_CARRY_TO_WORK);
                a.to_mem = (a.op == OP_FAR_ROTATE_LEFT_VIA_CARRY);
            end
            OP_FAR_ROTATE_RIGHT, OP_FAR_ROTATE_RIGHT_TO_WORK: begin
                a.result = rr;
                a.to_work = (a.op == OP_FAR_ROTATE_RIGHT_TO_WORK);
                a.to_mem = (a.op == OP_FAR_ROTATE_RIGHT);
            end
            OP_FAR_ROTATE_RIGHT_VIA_CARRY, OP_FAR_ROTATE_RIGHT_VIA_CARRY_TO_WORK: begin
                a.result = {a.flags_in[XMO_F_C], a.opnd[7:1]};
                a.flags_out[XMO_F_C] = a.opnd[0];
                a.to_work = (a.op == OP_FAR_ROTATE_RIGHT_VIA_CARRY_TO_WORK);
                a.to_mem = (a.op == OP_FAR_ROTATE_RIGHT_VIA_CARRY);
            end
            OP_FAR_MINUS_WITH_BORROW_TO_WORK, OP_FAR_MINUS_WITH_BORROW_TO_MEMORY,
            OP_FAR_MINUS_TO_WORK, OP_FAR_MINUS_TO_MEMORY: begin
                a.result = dif[7:0];
                a.to_work = (a.op == OP_FAR_MINUS_WITH_BORROW_TO_WORK) ||
                            (a.op == OP_FAR_MINUS_TO_WORK);
                a.to_mem = ~a.to_work;
                a.flags_out[XMO_F_C] = dif[8];
                a.flags_out[XMO_F_AC] = nib[4];
                a.flags_out[XMO_F_Z] = (dif[7:0] == 8'h00);
                a.flags_out[XMO_F_OV] = (a.acc[7] != a.opnd[7]) && (dif[7] != a.acc[7]);
                a.flags_out[XMO_F_SC] = a.flags_out[XMO_F_OV] ^ dif[7];
                // The borrow forms chain zero across bytes of a wide subtract.
                a.flags_out[XMO_F_CZ] = (dif[7:0] == 8'h00) &&
                                        (~sbc || a.flags_in[XMO_F_CZ]);
            end
            OP_FAR_DECREMENT_SKIP_IF_NIL, OP_FAR_DECREMENT_SKIP_TO_WORK: begin
                a.result = dec;
                a.to_work = (a.op == OP_FAR_DECREMENT_SKIP_TO_WORK);
                a.to_mem = ~a.to_work;
                a.skip = (dec == 8'h00);
            end
            OP_FAR_INCREMENT_SKIP_IF_NIL, OP_FAR_INCREMENT_SKIP_TO_WORK: begin
                a.result = inc;
                a.to_work = (a.op == OP_FAR_INCREMENT_SKIP_TO_WORK);
                a.to_mem = ~a.to_work;
                a.skip = (inc == 8'h00);
            end
            OP_FAR_FILL_ONES: begin
                a.result = 8'hff;
                a.to_mem = 1'b1;
            end
            OP_FAR_FILL_ONES_BIT: begin
                a.result = a.opnd | mask;
                a.to_mem = 1'b1;
            end
            OP_FAR_SKIP_IF_NONNIL_BIT: begin
                a.skip = |(a.opnd & mask);
            end
            OP_FAR_SKIP_IF_NONNIL: begin
                a.to_mem = 1'b1;
                a.skip = |a.opnd;
            end
            default: begin
                a.result = a.opnd;
            end
        endcase
    end

endmodule
`default_nettype wire

/* File: core/xmo_top.sv */
`timescale 1ns/1ns
`default_nettype none
//
// Overview of operation
// - Command carries a full flat byte address; no bank selection is used.
// - Store copies the work register into the byte; flags stay as they were.
// - OR of work and byte to work or byte; only zero flag updates.
// - Plain left rotate moves bit 7 into bit 0; no flag changes.
// - Left rotate via carry: old carry into bit 0, bit 7 into carry.
// - Plain right rotate moves bit 0 into bit 7; no flag changes.
// - Right rotate via carry: old carry into bit 7, bit 0 into carry.
// - Rotates to work write the work register and leave the byte alone.
// - Borrow subtract is work minus byte minus inverted carry, six flags.
// - Plain subtract is work minus byte, same six flags.
// - Subtract carry is 0 for a negative result, 1 otherwise.
// - Decrement byte, write back, skip next when new value is zero.
// - Work forms of decrement/increment write only work and skip on it.
// - Increment byte, write back, skip next when new value is zero.
// - A taken skip takes three cycles with one dummy cycle.
// - Fill writes all ones into the byte, flags untouched.
// - Bit set forces the chosen bit to one, others and flags kept.
// - Bit test skips next when the chosen bit is one.
// - Byte test rewrites the byte and skips next when it is nonzero.
module xmo_top #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [xmo_pkg::XMO_PAW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy,
    output logic skip
);
    import xmo_pkg::*;

    // Sizes the logic cannot serve are refused while elaborating.
    if (AW < 1 || AW > 16 || DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_size
        $error("xmo_top: DEPTH must be 2..2**AW and AW 1..16");
    end

    typedef struct packed {
        xmo_state_e st;
        xmo_op_e op;
        logic [2:0] bsel;
        logic [AW-1:0] addr;
        logic [7:0] opnd;
        logic [7:0] work;
        logic [5:0] flags;
        logic [AW-1:0] ptr;
        logic last_skip;
        logic [3:0] cyc;
        logic busy;
        logic skip;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [DEPTH-1:0][7:0] mem;
    } xmo_regs_s;

    localparam xmo_regs_s XMO_REGS_RST = '{
        st: ST_IDLE,
        op: OP_FAR_STORE_FROM_WORK,
        work: XMO_WORK_RST,
        flags: XMO_FLAGS_RST,
        default: '0
    };

    xmo_regs_s regs_r;
    xmo_regs_s regs_nxt;
    xmo_alu_if alu_bus ();

    logic access;
    logic decide;
    logic commit;
    logic [7:0] ofs;
    logic mapped;
    logic refuse;
    logic [AW-1:0] cmd_addr;
    logic [4:0] cmd_op;

    xmo_alu u_alu (
        .a(alu_bus)
    );

    // The datapath always sees the latched operation and operand.
    assign alu_bus.op = regs_r.op;
    assign alu_bus.bsel = regs_r.bsel;
    assign alu_bus.acc = regs_r.work;
    assign alu_bus.opnd = regs_r.opnd;
    assign alu_bus.flags_in = regs_r.flags;

    // One wait state: the answer is prepared in the first access cycle.
    assign access = psel && penable;
    assign decide = access && !regs_r.pready;
    assign commit = access && regs_r.pready;
    assign ofs = paddr;
    assign cmd_op = pwdata[XMO_CMD_OP_LSB +: 5];
    assign cmd_addr = pwdata[XMO_CMD_ADDR_LSB +: AW];

    // Offsets that name a register; anything else answers with an error.
    always_comb begin
        case (ofs)
            XMO_OFS_CMD, XMO_OFS_WORK, XMO_OFS_FLAGS,
            XMO_OFS_STAT, XMO_OFS_PTR, XMO_OFS_DATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // A write to any offset but the status one while an operation runs would race the datapath, so it is
    // refused; a command must name a known code and an existing byte.
    always_comb begin
        refuse = !mapped;
        if (pwrite && mapped && ofs != XMO_OFS_STAT) begin
            if (regs_r.busy) begin
                refuse = 1'b1;
            end
            if (ofs == XMO_OFS_CMD &&
                (cmd_op > XMO_OP_LAST || 32'(cmd_addr) >= DEPTH)) begin
                refuse = 1'b1;
            end
            if (ofs == XMO_OFS_PTR && 32'(pwdata[AW-1:0]) >= DEPTH) begin
                refuse = 1'b1;
            end
        end
    end

    // Next-state logic for the bus slave and the execution sequence.
    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.pready = decide;
        if (decide) begin
            regs_nxt.pslverr = refuse;
            regs_nxt.prdata = 32'h0000_0000;
            if (!pwrite && mapped) begin
                case (ofs)
                    XMO_OFS_CMD: begin
                        regs_nxt.prdata[XMO_CMD_OP_LSB +: 5] = regs_r.op;
                        regs_nxt.prdata[XMO_CMD_BIT_LSB +: 3] = regs_r.bsel;
                        regs_nxt.prdata[XMO_CMD_ADDR_LSB +: AW] = regs_r.addr;
                    end
                    XMO_OFS_WORK: regs_nxt.prdata[7:0] = regs_r.work;
                    XMO_OFS_FLAGS: regs_nxt.prdata[5:0] = regs_r.flags;
                    XMO_OFS_STAT: begin
                        regs_nxt.prdata[XMO_ST_BUSY] = regs_r.busy;
                        regs_nxt.prdata[XMO_ST_SKIP] = regs_r.last_skip;
                        regs_nxt.prdata[XMO_ST_CYC_LSB +: 4] = regs_r.cyc;
                    end
                    XMO_OFS_PTR: regs_nxt.prdata[AW-1:0] = regs_r.ptr;
                    XMO_OFS_DATA: regs_nxt.prdata[7:0] = regs_r.mem[regs_r.ptr];
                    default: regs_nxt.prdata = 32'h0000_0000;
                endcase
            end
        end else if (!access) begin
            regs_nxt.pslverr = 1'b0;
        end

        // Register writes take effect only at the completing edge.
        if (commit && pwrite && !regs_r.pslverr) begin
            case (ofs)
                XMO_OFS_CMD: begin
                    regs_nxt.op = xmo_op_e'(cmd_op);
                    regs_nxt.bsel = pwdata[XMO_CMD_BIT_LSB +: 3];
                    regs_nxt.addr = cmd_addr;
                    regs_nxt.st = ST_READ;
                end
                XMO_OFS_WORK: regs_nxt.work = pwdata[7:0];
                XMO_OFS_FLAGS: regs_nxt.flags = pwdata[5:0];
                XMO_OFS_PTR: regs_nxt.ptr = pwdata[AW-1:0];
                XMO_OFS_DATA: regs_nxt.mem[regs_r.ptr] = pwdata[7:0];
                default: regs_nxt.ptr = regs_r.ptr;
            endcase
        end

        // Read the byte, execute, then one dummy cycle if the skip is taken.
        case (regs_r.st)
            ST_IDLE: begin
                regs_nxt.last_skip = regs_r.last_skip;
            end
            ST_READ: begin
                regs_nxt.opnd = regs_r.mem[regs_r.addr];
                regs_nxt.st = ST_EXEC;
            end
            ST_EXEC: begin
                if (alu_bus.to_work) begin
                    regs_nxt.work = alu_bus.result;
                end
                if (alu_bus.to_mem) begin
                    regs_nxt.mem[regs_r.addr] = alu_bus.result;
                end
                regs_nxt.flags = alu_bus.flags_out;
                regs_nxt.last_skip = alu_bus.skip;
                if (alu_bus.skip) begin
                    regs_nxt.st = ST_DUMMY;
                    regs_nxt.cyc = XMO_SKIP_CYCLES;
                end else begin
                    regs_nxt.st = ST_IDLE;
                    regs_nxt.cyc = XMO_BASE_CYCLES;
                end
            end
            ST_DUMMY: begin
                regs_nxt.st = ST_IDLE;
            end
            default: begin
                regs_nxt.st = ST_IDLE;
            end
        endcase

        regs_nxt.busy = (regs_nxt.st != ST_IDLE);
        regs_nxt.skip = (regs_nxt.st == ST_DUMMY);
    end

    // All state is held in one register so reset covers every field.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regs_r <= XMO_REGS_RST;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign prdata = regs_r.prdata;
    assign pready = regs_r.pready;
    assign pslverr = regs_r.pslverr;
    assign busy = regs_r.busy;
    assign skip = regs_r.skip;

endmodule
`default_nettype wire

/* File: sim/xmo_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// Bus handshake and operation timing seen from the pins only.
module xmo_chk
    import xmo_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [xmo_pkg::XMO_PAW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy,
    input wire logic skip
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // One wait state, then a single answer pulse.
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    // An accepted command runs at least the base two cycles.
    op_start_a: assert property (pready && pwrite && !pslverr && paddr == XMO_OFS_CMD
        |=> busy ##1 busy) else $error("command did not run two cycles");
    bad_op_a: assert property (pready && pwrite && paddr == XMO_OFS_CMD
        && pwdata[4:0] > XMO_OP_LAST |-> pslverr ##1 !busy) else $error("bad opcode run");
    // A taken skip adds exactly one dummy cycle, flagged by skip.
    busy_max_a: assert property (busy [*3] |=> !busy)
        else $error("operation longer than three cycles");
    skip_third_a: assert property ($rose(skip) |-> busy && $past(busy) && $past(busy, 2))
        else $error("skip not in third busy cycle");
    skip_end_a: assert property (skip |=> !skip && !busy)
        else $error("skip cycle not the last");
    third_skip_a: assert property (busy && $past(busy) && $past(busy, 2) |-> skip)
        else $error("third cycle without skip");
    // Software must not disturb work or flags while an operation runs.
    busy_lock_a: assert property (pready && pwrite && $past(busy)
        && paddr != XMO_OFS_STAT |-> pslverr) else $error("write accepted while busy");
    cover property ($rose(skip));
    cover property (busy [*2] ##1 !busy);
    cover property (pready && pslverr);
endmodule
`default_nettype wire

/* File: sim/xmo_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Bus master that stands for the core side; tasks are called by the bench.
module xmo_host (
    input wire logic pclk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic tmo
);
    // Idle bus from time zero so no stray request is seen.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tmo = 1'b0;
    end

    // One transfer; the request is held until pready is sampled high, for at most 16 cycles.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) tmo <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import xmo_pkg::*;
    // Fewer bytes than the address field can name, so out-of-range refusals are reachable.
    localparam int DEPTH = 8;
    localparam int AW = 4;
    localparam logic [32:0] ERR = 33'h1_0000_0000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire logic psel, penable, pwrite, pready, pslverr, busy, skip, tmo;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    logic [32:0] expq[$];
    int error_cnt = 0;
    int n_checks = 0;
    logic [15:0] lf = 16'h5be6;

    always #5 pclk = ~pclk;

    xmo_top #(.DEPTH(DEPTH), .AW(AW)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .skip(skip));
    xmo_host h_u (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tmo(tmo));

    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction

    // Reference result of one operation: work, byte, flags and skip.
    function automatic void model(input logic [4:0] op, input logic [2:0] b,
        input logic [7:0] w, input logic [7:0] m, input logic [5:0] f,
        output logic [7:0] nw, output logic [7:0] nm, output logic [5:0] nf, output logic sk);
        logic [8:0] d;
        logic [4:0] h;
        logic ci;
        ci = (op == 5'h0b || op == 5'h0c) ? ~f[0] : 1'b0;
        d = {1'b0, w} - {1'b0, m} - {8'h0, ci};
        h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ci};
        nw = w;
        nm = m;
        nf = f;
        sk = 1'b0;
        case (op)
            5'h00: nm = w;
            5'h01: begin nw = w | m; nf[2] = (nw == 8'h0); end
            5'h02: begin nm = w | m; nf[2] = (nm == 8'h0); end
            5'h03: nm = {m[6:0], m[7]};
            5'h04: nw = {m[6:0], m[7]};
            5'h05: begin nm = {m[6:0], f[0]}; nf[0] = m[7]; end
            5'h06: begin nw = {m[6:0], f[0]}; nf[0] = m[7]; end
            5'h07: nm = {m[0], m[7:1]};
            5'h08: nw = {m[0], m[7:1]};
            5'h09: begin nm = {f[0], m[7:1]}; nf[0] = m[0]; end
            5'h0a: begin nw = {f[0], m[7:1]}; nf[0] = m[0]; end
            5'h0b, 5'h0c, 5'h15, 5'h16: begin
                nf[0] = ~d[8];
                nf[1] = ~h[4];
                nf[2] = (d[7:0] == 8'h0);
                nf[3] = (w[7] != m[7]) && (d[7] != w[7]);
                nf[4] = nf[3] ^ d[7];
                nf[5] = (op < 5'h0d) ? nf[2] & f[5] : nf[2];
                if (op == 5'h0c || op == 5'h16) nm = d[7:0];
                else nw = d[7:0];
            end
            5'h0d: begin nm = m - 8'h1; sk = (nm == 8'h0); end
            5'h0e: begin nw = m - 8'h1; sk = (nw == 8'h0); end
            5'h0f: nm = 8'hff;
            5'h10: nm[b] = 1'b1;
            5'h11: begin nm = m + 8'h1; sk = (nm == 8'h0); end
            5'h12: begin nw = m + 8'h1; sk = (nw == 8'h0); end
            5'h13: sk = (m != 8'h0);
            5'h14: sk = m[b];
            default: ;
        endcase
    endfunction

    // Notes the expected answer, then runs the transfer.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        expq.push_back(e);
        h_u.xfer(w, a, d);
    endtask

    task automatic summarize();
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Every completed transfer is matched against the oldest note.
    always @(posedge pclk) begin
        if (tmo === 1'b1) begin error_cnt++; summarize(); end
        if (psel && penable && pready === 1'b1)
            `CHK({pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front())
    end

    initial begin
        logic [7:0] w, m, nw, nm;
        logic [5:0] f, nf;
        logic [3:0] a, bc, sc;
        logic [2:0] b;
        logic sk;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state, then refused and ignored accesses.
        bus(0, XMO_OFS_WORK, 32'h0, 33'h0);
        bus(0, XMO_OFS_FLAGS, 32'h0, 33'h0);
        bus(0, XMO_OFS_DATA, 32'h0, 33'h0);
        bus(0, 8'h18, 32'h0, ERR);
        bus(1, 8'h02, 32'h1, ERR);
        bus(1, XMO_OFS_STAT, 32'hff, 33'h0);
        bus(1, XMO_OFS_CMD, 32'h17, ERR);
        bus(1, XMO_OFS_CMD, 32'h0008_000f, ERR);
        bus(1, XMO_OFS_PTR, 32'h08, ERR);
        bus(0, XMO_OFS_STAT, 32'h0, 33'h0);
        // Every opcode, first with a boundary byte, then with random operands.
        for (int op = 0; op <= 22; op++) begin
            for (int k = 0; k < 3; k++) begin
                {w, m} = rnd();
                {f, a, b} = 13'(rnd());
                a = a & 4'h7; // Keep the byte address below DEPTH.
                if (k == 0) m = (op == 13 || op == 14) ? 8'h01 : (op == 17 || op == 18) ? 8'hff : 8'h00;
                model(op[4:0], b, w, m, f, nw, nm, nf, sk);
                bus(1, XMO_OFS_WORK, {24'h0, w}, 33'h0);
                bus(1, XMO_OFS_FLAGS, {26'h0, f}, 33'h0);
                bus(1, XMO_OFS_PTR, {28'h0, a}, 33'h0);
                bus(1, XMO_OFS_DATA, {24'h0, m}, 33'h0);
                bus(1, XMO_OFS_CMD, {12'h0, a, 5'h0, b, 3'h0, op[4:0]}, 33'h0);
                bc = 4'h0;
                sc = 4'h0;
                repeat (8) begin
                    @(posedge pclk);
                    bc = bc + {3'h0, busy};
                    sc = sc + {3'h0, skip};
                end
                `CHK(bc, 4'h2 + {3'h0, sk})
                `CHK(sc, {3'h0, sk})
                bus(0, XMO_OFS_WORK, {24'h0, nw}, {25'h0, nw});
                bus(0, XMO_OFS_FLAGS, {26'h0, nf}, {27'h0, nf});
                bus(0, XMO_OFS_DATA, {24'h0, nm}, {25'h0, nm});
                bus(0, XMO_OFS_STAT, 32'h0, {21'h0, 4'h2 + {3'h0, sk}, 6'h0, sk, 1'b0});
            end
        end
        // A write landing in the dummy cycle of a taken skip is refused.
        bus(1, XMO_OFS_WORK, 32'h33, 33'h0);
        bus(1, XMO_OFS_DATA, 32'h5a, 33'h0);
        bus(1, XMO_OFS_CMD, {12'h0, a, 16'h0013}, 33'h0);
        bus(1, XMO_OFS_WORK, 32'h77, ERR);
        bus(0, XMO_OFS_WORK, 32'h0, 33'h33);
        bus(0, XMO_OFS_STAT, 32'h0, 33'h0302);
        // A reset while no operation runs must bring work, flags and status back to zero.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        bus(0, XMO_OFS_WORK, 32'h0, 33'h0);
        bus(0, XMO_OFS_FLAGS, 32'h0, 33'h0);
        bus(0, XMO_OFS_STAT, 32'h0, 33'h0);
        repeat (2) @(posedge pclk);
        summarize();
    end
endmodule

bind xmo_top xmo_chk #(.DEPTH(DEPTH), .AW(AW)) chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .skip(skip));
`default_nettype wire
